// file: rtl/srt_map.svh
// Purpose: constants for the shift, rotate and table execution unit
// Assumes: 16-bit data path, 24-bit program words
// Notes: definitions only
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH
`define SRT_DATA_W 16
`define SRT_PROG_W 24
`define SRT_ACC_W 40
`define SRT_ACC_SAT_BIT 31
`define SRT_CYC_ONE 2'd1
`define SRT_CYC_TWO 2'd2
`define SRT_HI_LSB 16
`define SRT_HI_MSB 23
`endif

// file: rtl/srt_pkg.sv
// Purpose: types for the shift, rotate and table execution unit
// Assumes: srt_map.svh holds the numbers
// Notes: none
`include "srt_map.svh"
package srt_pkg;
    // Operation codes
    typedef enum logic [3:0] {
        SRT_OP_NONE = 4'h0,
        SRT_OP_ROTATE_RIGHT_NO_CARRY = 4'h1,
        SRT_OP_SHIFT_LEFT_REG = 4'h2,
        SRT_OP_SHIFT_LEFT_IMM = 4'h3,
        SRT_OP_ACCUM_SHIFT_REG = 4'h4,
        SRT_OP_ACCUM_SHIFT_IMM = 4'h5,
        SRT_OP_TABLE_READ_HIGH = 4'h6,
        SRT_OP_TABLE_READ_LOW = 4'h7,
        SRT_OP_TABLE_WRITE_HIGH = 4'h8,
        SRT_OP_TABLE_WRITE_LOW = 4'h9,
        SRT_OP_SUBTRACT_WITH_BORROW = 4'ha,
        SRT_OP_SHIFT_LEFT_ONE = 4'hb
    } srt_op_t;
    // Core status flags
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic negative;
        logic overflow_flag;
        logic zero;
    } srt_flags_t;
    // Accumulator status flags
    typedef struct packed {
        logic accum_a_overflow;
        logic accum_b_overflow;
        logic combined_overflow;
        logic accum_a_saturate;
        logic accum_b_saturate;
        logic combined_saturate;
    } srt_acc_flags_t;
    // Execution state
    typedef enum logic [1:0] {
        SRT_ST_IDLE = 2'b01,
        SRT_ST_TABLE = 2'b10
    } srt_state_t;
endpackage : srt_pkg

// file: rtl/srt_acc_shift.sv
// Purpose: accumulator arithmetic shift with overflow and saturation status
// Assumes: shift amount signed, positive shifts right
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "srt_map.svh"
module srt_acc_shift
    import srt_pkg::*;
#(
    parameter int ACC_W = `SRT_ACC_W
) (
    input wire logic [ACC_W-1:0] acc_in, // Accumulator value
    input wire logic signed [5:0] amount, // Signed shift amount
    output logic [ACC_W-1:0] acc_out, // Shifted value
    output logic ovf, // Beyond bit 31
    output logic sat // Catastrophic overflow beyond bit 39
);
    logic signed [ACC_W:0] wide;
    logic [5:0] mag;
    // Positive amounts shift right; negative shift left with a guard bit
    always_comb begin
        mag = amount[5] ? 6'(-amount) : 6'(amount);
        if (amount[5]) begin
            wide = $signed({acc_in[ACC_W-1], acc_in}) <<< mag;
        end else begin
            wide = $signed({acc_in[ACC_W-1], acc_in}) >>> mag;
        end
        acc_out = wide[ACC_W-1:0];
        // Top bits not all equal means the value left the 32-bit range
        ovf = ~((&wide[ACC_W-1:`SRT_ACC_SAT_BIT]) | ~(|wide[ACC_W-1:`SRT_ACC_SAT_BIT]));
        // Guard differs from sign: the 40-bit word itself overflowed
        sat = wide[ACC_W] ^ wide[ACC_W-1];
    end
endmodule : srt_acc_shift
`default_nettype wire

// file: rtl/srt_exec.sv
// Purpose: execute shift, rotate, borrow subtract and table transfer operations
// Assumes: operands arrive with the start strobe; program memory answers in one cycle
// Notes: outputs are registered; busy covers the second cycle of table operations
// Operation
// - Rotate right without carry feeds bit 0 into bit 15 in one cycle and updates only negative and zero.
// - Shift left by a register amount writes the result in one cycle and updates only negative and zero.
// - Shift left by a 5-bit immediate takes one cycle and updates only negative and zero.
// - Accumulator shift by a register amount takes one cycle and updates the selected accumulator's overflow and saturate flags and both combined flags.
// - Accumulator shift by a signed 6-bit immediate takes one cycle and updates the same flags.
// - Table read high puts program bits 23 to 16 in the low byte of the result in two cycles, no flags.
// - Table read low puts program bits 15 to 0 in the result in two cycles, no flags.
// - Table write high puts the source low byte into program bits 23 to 16 in two cycles, no flags.
// - Table write low puts the whole source into program bits 15 to 0 in two cycles, no flags.
`timescale 1ns/1ps
`default_nettype none
`include "srt_map.svh"
module srt_exec
    import srt_pkg::*;
#(
    parameter int DATA_W = `SRT_DATA_W,
    parameter int PROG_W = `SRT_PROG_W,
    parameter int ACC_W = `SRT_ACC_W
) (
    input wire logic clock, // 20 MHz core clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic start, // Operation request pulse
    input wire srt_op_t op, // Operation code
    input wire logic [DATA_W-1:0] source_work_reg, // Source operand
    input wire logic [DATA_W-1:0] base_work_reg, // Base operand
    input wire logic [3:0] amount_reg, // Register shift amount
    input wire logic [4:0] unsigned_imm5, // Immediate shift amount
    input wire logic signed [5:0] signed_imm6, // Immediate accumulator shift
    input wire logic acc_sel, // Zero selects accumulator A
    input wire logic [ACC_W-1:0] acc_a_in, // Accumulator A
    input wire logic [ACC_W-1:0] acc_b_in, // Accumulator B
    input wire srt_flags_t flags_in, // Current core flags
    input wire srt_acc_flags_t acc_flags_in, // Current accumulator flags
    input wire logic [PROG_W-1:0] prog_rdata, // Program word, valid cycle after request
    output logic busy, // Table operation in progress
    output logic done, // Result valid pulse
    output logic [DATA_W-1:0] dest_reg, // Result word
    output logic [ACC_W-1:0] acc_out, // Shifted accumulator
    output logic acc_we, // Accumulator write pulse
    output srt_flags_t flags_out, // Updated core flags
    output srt_acc_flags_t acc_flags_out, // Updated accumulator flags
    output logic prog_re, // Program read pulse
    output logic prog_we, // Program latch write pulse
    output logic [PROG_W-1:0] prog_wdata, // Latch write data
    output logic [PROG_W-1:0] prog_wmask // Latch bit enables
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return ~(|v);
    endfunction : is_zero
    srt_state_t state_ff, nxt_state;
    srt_op_t op_ff, nxt_op;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [DATA_W-1:0] dest_ff, nxt_dest;
    logic [ACC_W-1:0] acc_ff, nxt_acc;
    logic acc_we_ff, nxt_acc_we;
    srt_flags_t flags_ff, nxt_flags;
    srt_acc_flags_t aflags_ff, nxt_aflags;
    logic prog_re_ff, nxt_prog_re;
    logic prog_we_ff, nxt_prog_we;
    logic [PROG_W-1:0] wdata_ff, nxt_wdata;
    logic [PROG_W-1:0] wmask_ff, nxt_wmask;
    logic [ACC_W-1:0] sh_acc;
    logic sh_ovf, sh_sat;
    logic signed [5:0] acc_amt;
    logic [DATA_W:0] diff;
    logic [4:0] low_diff;
    // ------------------------------------------------------------
    // Accumulator shifter
    // ------------------------------------------------------------
    // Register amount is treated as a signed 4-bit count, sign extended
    assign acc_amt = (op == SRT_OP_ACCUM_SHIFT_IMM) ? signed_imm6 : 6'($signed(amount_reg));
    srt_acc_shift #(.ACC_W(ACC_W)) u_acc_shift (
        .acc_in(acc_sel ? acc_b_in : acc_a_in),
        .amount(acc_amt),
        .acc_out(sh_acc),
        .ovf(sh_ovf),
        .sat(sh_sat)
    );
    // Borrow subtract: carry is not-borrow, so the subtrahend grows by inverted carry
    assign diff = {1'b0, base_work_reg} - {1'b0, source_work_reg} - {16'h0000, ~flags_in.carry};
    assign low_diff = {1'b0, base_work_reg[3:0]} - {1'b0, source_work_reg[3:0]} - {4'h0, ~flags_in.carry};
    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Flags default to their inputs so untouched bits pass through unchanged
    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_busy = 1'b0;
        nxt_done = 1'b0;
        nxt_dest = dest_ff;
        nxt_acc = acc_ff;
        nxt_acc_we = 1'b0;
        nxt_flags = flags_ff;
        nxt_aflags = aflags_ff;
        nxt_prog_re = 1'b0;
        nxt_prog_we = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_wmask = wmask_ff;
        case (state_ff)
            SRT_ST_IDLE: begin
                if (start) begin
                    nxt_flags = flags_in;
                    nxt_aflags = acc_flags_in;
                    nxt_op = op;
                    nxt_done = 1'b1;
                    case (op)
                        SRT_OP_ROTATE_RIGHT_NO_CARRY: begin
                            nxt_dest = {source_work_reg[0], source_work_reg[DATA_W-1:1]};
                            nxt_flags.negative = source_work_reg[0];
                            nxt_flags.zero = is_zero(source_work_reg);
                        end
                        SRT_OP_SHIFT_LEFT_REG: begin
                            nxt_dest = base_work_reg << amount_reg;
                            nxt_flags.negative = nxt_dest[DATA_W-1];
                            nxt_flags.zero = is_zero(nxt_dest);
                        end
                        SRT_OP_SHIFT_LEFT_IMM: begin
                            // Amounts of 16 and above clear the word
                            nxt_dest = base_work_reg << unsigned_imm5;
                            nxt_flags.negative = nxt_dest[DATA_W-1];
                            nxt_flags.zero = is_zero(nxt_dest);
                        end
                        SRT_OP_ACCUM_SHIFT_REG, SRT_OP_ACCUM_SHIFT_IMM: begin
                            nxt_acc = sh_acc;
                            nxt_acc_we = 1'b1;
                            if (acc_sel) begin
                                nxt_aflags.accum_b_overflow = sh_ovf;
                                nxt_aflags.accum_b_saturate = acc_flags_in.accum_b_saturate | sh_sat;
                            end else begin
                                nxt_aflags.accum_a_overflow = sh_ovf;
                                nxt_aflags.accum_a_saturate = acc_flags_in.accum_a_saturate | sh_sat;
                            end
                            nxt_aflags.combined_overflow = nxt_aflags.accum_a_overflow | nxt_aflags.accum_b_overflow;
                            nxt_aflags.combined_saturate = nxt_aflags.accum_a_saturate | nxt_aflags.accum_b_saturate;
                        end
                        SRT_OP_TABLE_READ_HIGH, SRT_OP_TABLE_READ_LOW: begin
                            nxt_done = 1'b0;
                            nxt_busy = 1'b1;
                            nxt_prog_re = 1'b1;
                            nxt_state = SRT_ST_TABLE;
                        end
                        SRT_OP_TABLE_WRITE_HIGH: begin
                            nxt_done = 1'b0;
                            nxt_busy = 1'b1;
                            nxt_prog_we = 1'b1;
                            nxt_wdata = {source_work_reg[7:0], 16'h0000};
                            nxt_wmask = 24'hff0000;
                            nxt_state = SRT_ST_TABLE;
                        end
                        SRT_OP_TABLE_WRITE_LOW: begin
                            nxt_done = 1'b0;
                            nxt_busy = 1'b1;
                            nxt_prog_we = 1'b1;
                            nxt_wdata = {8'h00, source_work_reg};
                            nxt_wmask = 24'h00ffff;
                            nxt_state = SRT_ST_TABLE;
                        end
                        SRT_OP_SUBTRACT_WITH_BORROW: begin
                            nxt_dest = diff[DATA_W-1:0];
                            nxt_flags.carry = ~diff[DATA_W];
                            nxt_flags.digit_carry_flag = ~low_diff[4];
                            nxt_flags.negative = diff[DATA_W-1];
                            nxt_flags.overflow_flag = (base_work_reg[DATA_W-1] ^ source_work_reg[DATA_W-1]) &
                                                      (base_work_reg[DATA_W-1] ^ diff[DATA_W-1]);
                            nxt_flags.zero = is_zero(diff[DATA_W-1:0]);
                        end
                        SRT_OP_SHIFT_LEFT_ONE: begin
                            nxt_dest = {source_work_reg[DATA_W-2:0], 1'b0};
                            nxt_flags.carry = source_work_reg[DATA_W-1];
                            nxt_flags.negative = source_work_reg[DATA_W-2];
                            nxt_flags.overflow_flag = source_work_reg[DATA_W-1] ^ source_work_reg[DATA_W-2];
                            nxt_flags.zero = is_zero({source_work_reg[DATA_W-2:0], 1'b0});
                        end
                        default: begin
                            nxt_done = 1'b0;
                        end
                    endcase
                end
            end
            SRT_ST_TABLE: begin
                // Second cycle: program data is back, flags stay as sampled
                nxt_done = 1'b1;
                nxt_state = SRT_ST_IDLE;
                if (op_ff == SRT_OP_TABLE_READ_HIGH) begin
                    nxt_dest = {8'h00, prog_rdata[`SRT_HI_MSB:`SRT_HI_LSB]};
                end else if (op_ff == SRT_OP_TABLE_READ_LOW) begin
                    nxt_dest = prog_rdata[DATA_W-1:0];
                end
            end
            default: begin
                nxt_state = SRT_ST_IDLE;
            end
        endcase
    end
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SRT_ST_IDLE;
            op_ff <= SRT_OP_NONE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            dest_ff <= 16'h0000;
            acc_ff <= 40'h0000000000;
            acc_we_ff <= 1'b0;
            flags_ff <= 5'h00;
            aflags_ff <= 6'h00;
            prog_re_ff <= 1'b0;
            prog_we_ff <= 1'b0;
            wdata_ff <= 24'h000000;
            wmask_ff <= 24'h000000;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            dest_ff <= nxt_dest;
            acc_ff <= nxt_acc;
            acc_we_ff <= nxt_acc_we;
            flags_ff <= nxt_flags;
            aflags_ff <= nxt_aflags;
            prog_re_ff <= nxt_prog_re;
            prog_we_ff <= nxt_prog_we;
            wdata_ff <= nxt_wdata;
            wmask_ff <= nxt_wmask;
        end
    end
    assign busy = busy_ff;
    assign done = done_ff;
    assign dest_reg = dest_ff;
    assign acc_out = acc_ff;
    assign acc_we = acc_we_ff;
    assign flags_out = flags_ff;
    assign acc_flags_out = aflags_ff;
    assign prog_re = prog_re_ff;
    assign prog_we = prog_we_ff;
    assign prog_wdata = wdata_ff;
    assign prog_wmask = wmask_ff;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    rotate_result_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_ROTATE_RIGHT_NO_CARRY) |=>
        (done && dest_reg == {$past(source_work_reg[0]), $past(source_work_reg[DATA_W-1:1])} &&
         flags_out.carry == $past(flags_in.carry)))
        else $error("rotate result or carry wrong");
    shift_reg_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_SHIFT_LEFT_REG) |=>
        (done && flags_out.overflow_flag == $past(flags_in.overflow_flag) && flags_out.zero == (dest_reg == 16'h0000)))
        else $error("register shift flags wrong");
    shift_imm_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_SHIFT_LEFT_IMM) |=>
        (done && flags_out.carry == $past(flags_in.carry) && flags_out.negative == dest_reg[DATA_W-1]))
        else $error("immediate shift flags wrong");
    acc_shift_once_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_ACCUM_SHIFT_REG) |=> (acc_we && done && !busy))
        else $error("accumulator shift not single cycle");
    acc_combined_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_ACCUM_SHIFT_IMM) |=> (acc_we && done &&
         acc_flags_out.combined_overflow == (acc_flags_out.accum_a_overflow | acc_flags_out.accum_b_overflow)))
        else $error("combined overflow inconsistent");
    table_read_high_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_TABLE_READ_HIGH) ##1 clk_en |=>
        (done && dest_reg == {8'h00, $past(prog_rdata[`SRT_HI_MSB:`SRT_HI_LSB])}))
        else $error("table read high wrong");
    table_read_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_TABLE_READ_LOW) ##1 clk_en |->
        (prog_re && busy && !done) ##1 (done && flags_out == $past(flags_out)))
        else $error("table read low timing wrong");
    table_write_high_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_TABLE_WRITE_HIGH) |=>
        (prog_we && prog_wmask == 24'hff0000 && prog_wdata[23:16] == $past(source_work_reg[7:0])))
        else $error("table write high wrong");
    table_write_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_TABLE_WRITE_LOW) |=>
        (prog_we && prog_wmask == 24'h00ffff && prog_wdata[15:0] == $past(source_work_reg)))
        else $error("table write low wrong");
    borrow_sub_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_SUBTRACT_WITH_BORROW) |=>
        (dest_reg == 16'($past(base_work_reg) - $past(source_work_reg) - {15'h0000, ~$past(flags_in.carry)})))
        else $error("borrow subtract result wrong");
    shift_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && start && state_ff == SRT_ST_IDLE && op == SRT_OP_SHIFT_LEFT_ONE) |=>
        (flags_out.carry == $past(source_work_reg[DATA_W-1]) && dest_reg[0] == 1'b0))
        else $error("single shift carry wrong");
endmodule : srt_exec
`default_nettype wire

// file: bench/shift_rotate_table_ops_tb.sv
// Purpose: self-checking bench for the shift, rotate and table execution unit
// Assumes: operands sampled with start; program word held steady around table reads
// Notes: assertions live in the design files, so no checker is bound here
`timescale 1ns/1ps
`default_nettype none
module shift_rotate_table_ops_tb;
    import srt_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, start = 1'b0, acc_sel = 1'b0;
    srt_op_t op = SRT_OP_NONE;
    logic [15:0] source_work_reg = 16'h0000, base_work_reg = 16'h0000;
    logic [3:0] amount_reg = 4'h0;
    logic [4:0] unsigned_imm5 = 5'h00;
    logic signed [5:0] signed_imm6 = 6'sh00;
    logic [39:0] acc_a_in = 40'h0, acc_b_in = 40'h0, acc_out;
    srt_flags_t flags_in = 5'h1b, flags_out, r_flags;
    srt_acc_flags_t acc_flags_in = 6'h00, acc_flags_out, r_accf;
    logic [23:0] prog_rdata = 24'ha51234, prog_wdata, prog_wmask, r_wdata, r_wmask;
    logic busy, done, acc_we, prog_re, prog_we, r_re, r_we, r_busy, r_accwe;
    logic [15:0] dest_reg, r_dest;
    logic [39:0] r_acc;
    int n_errors = 0, n_compared = 0, ndone, r_cyc;
    srt_exec dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .start(start), .op(op),
        .source_work_reg(source_work_reg), .base_work_reg(base_work_reg), .amount_reg(amount_reg),
        .unsigned_imm5(unsigned_imm5), .signed_imm6(signed_imm6), .acc_sel(acc_sel),
        .acc_a_in(acc_a_in), .acc_b_in(acc_b_in), .flags_in(flags_in), .acc_flags_in(acc_flags_in),
        .prog_rdata(prog_rdata), .busy(busy), .done(done), .dest_reg(dest_reg), .acc_out(acc_out),
        .acc_we(acc_we), .flags_out(flags_out), .acc_flags_out(acc_flags_out), .prog_re(prog_re),
        .prog_we(prog_we), .prog_wdata(prog_wdata), .prog_wmask(prog_wmask));
    // ------------------------------------------------------------
    // Clock and helpers
    // ------------------------------------------------------------
    always #25 clock = ~clock;
    task automatic end_sim();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // One request; hold keeps start up into the busy cycle, which must be ignored
    task automatic go(input srt_op_t o, input logic [15:0] s, input logic [15:0] b, input logic hold);
        @(posedge clock);
        start <= 1'b1;
        op <= o;
        source_work_reg <= s;
        base_work_reg <= b;
        @(posedge clock);
        if (!hold) start <= 1'b0;
        ndone = 0;
        r_cyc = 0;
        // Fixed four-cycle window bounds every wait; each look falls 1 ns after an edge
        for (int k = 1; k <= 4; k++) begin
            #1;
            if (k == 1) begin
                r_re = prog_re;
                r_we = prog_we;
                r_busy = busy;
            end
            if (done === 1'b1) begin
                ndone++;
                if (r_cyc == 0) begin
                    r_cyc = k;
                    r_dest = dest_reg;
                    r_flags = flags_out;
                    r_acc = acc_out;
                    r_accf = acc_flags_out;
                    r_wdata = prog_wdata & prog_wmask;
                    r_wmask = prog_wmask;
                    r_accwe = acc_we;
                end
            end
            @(posedge clock);
            if (k == 1) start <= 1'b0;
        end
        if (o != SRT_OP_NONE && ndone == 0) begin
            n_errors++;
            end_sim();
        end
    endtask : go
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        cmp(done, 1'b0);
        go(SRT_OP_ROTATE_RIGHT_NO_CARRY, 16'h0001, 16'h0000, 1'b0);
        cmp(r_dest, 16'h8000);
        cmp({r_cyc, r_flags}, {32'd1, 5'h1e});
        // Frozen enable must stretch done and hold the result
        @(posedge clock);
        start <= 1'b1;
        op <= SRT_OP_ROTATE_RIGHT_NO_CARRY;
        source_work_reg <= 16'h0003;
        @(posedge clock);
        start <= 1'b0;
        clk_en <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        cmp({done, dest_reg}, {1'b1, 16'h8001});
        @(posedge clock);
        clk_en <= 1'b1;
        amount_reg <= 4'h4;
        go(SRT_OP_SHIFT_LEFT_REG, 16'h0000, 16'h00f1, 1'b0);
        cmp({r_cyc, r_dest, r_flags}, {32'd1, 16'h0f10, 5'h1a});
        unsigned_imm5 <= 5'h10;
        go(SRT_OP_SHIFT_LEFT_IMM, 16'h0000, 16'hffff, 1'b0);
        cmp({r_cyc, r_dest, r_flags}, {32'd1, 16'h0000, 5'h1b});
        unsigned_imm5 <= 5'h0f;
        go(SRT_OP_SHIFT_LEFT_IMM, 16'h0000, 16'h0001, 1'b0);
        cmp({r_dest, r_flags}, {16'h8000, 5'h1e});
        flags_in <= 5'h00;
        go(SRT_OP_SHIFT_LEFT_ONE, 16'h8001, 16'h0000, 1'b0);
        cmp({r_cyc, r_dest, r_flags}, {32'd1, 16'h0002, 5'h12});
        go(SRT_OP_SUBTRACT_WITH_BORROW, 16'h0001, 16'h0010, 1'b0);
        cmp({r_dest, r_flags}, {16'h000e, 5'h10});
        flags_in <= 5'h10;
        go(SRT_OP_SUBTRACT_WITH_BORROW, 16'h0001, 16'h0001, 1'b0);
        cmp({r_dest, r_flags}, {16'h0000, 5'h19});
        // Arithmetic right shift keeps the sign of a negative accumulator
        acc_a_in <= 40'hff_ffff_ff00;
        signed_imm6 <= 6'sh04;
        go(SRT_OP_ACCUM_SHIFT_IMM, 16'h0000, 16'h0000, 1'b0);
        cmp({r_cyc, r_acc, r_accf, r_accwe}, {32'd1, 40'hff_ffff_fff0, 6'h00, 1'b1});
        acc_a_in <= 40'h00_4000_0000;
        signed_imm6 <= 6'sh3f;
        go(SRT_OP_ACCUM_SHIFT_IMM, 16'h0000, 16'h0000, 1'b0);
        cmp({r_acc, r_accf, r_flags}, {40'h00_8000_0000, 6'h28, 5'h10});
        acc_sel <= 1'b1;
        acc_a_in <= 40'h0;
        acc_b_in <= 40'h00_4000_0000;
        amount_reg <= 4'hf;
        go(SRT_OP_ACCUM_SHIFT_REG, 16'h0000, 16'h0000, 1'b0);
        cmp({r_cyc, r_acc, r_accf, r_accwe}, {32'd1, 40'h00_8000_0000, 6'h18, 1'b1});
        // Table reads; the first also holds start into the busy cycle
        go(SRT_OP_TABLE_READ_HIGH, 16'h0100, 16'h0000, 1'b1);
        cmp({ndone, r_cyc, r_re, r_busy}, {32'd1, 32'd2, 1'b1, 1'b1});
        cmp({r_dest[7:0], r_flags}, {8'ha5, 5'h10});
        go(SRT_OP_TABLE_READ_LOW, 16'h0100, 16'h0000, 1'b0);
        cmp({r_cyc, r_re, r_dest, r_flags}, {32'd2, 1'b1, 16'h1234, 5'h10});
        go(SRT_OP_TABLE_WRITE_HIGH, 16'h5a3c, 16'h0000, 1'b0);
        cmp({r_cyc, r_we, r_wdata, r_wmask, r_flags}, {32'd2, 1'b1, 24'h3c0000, 24'hff0000, 5'h10});
        go(SRT_OP_TABLE_WRITE_LOW, 16'h5a3c, 16'h0000, 1'b0);
        cmp({r_cyc, r_we, r_wdata, r_wmask, r_flags}, {32'd2, 1'b1, 24'h005a3c, 24'h00ffff, 5'h10});
        go(SRT_OP_NONE, 16'h0000, 16'h0000, 1'b0);
        cmp(ndone, 32'd0);
        end_sim();
    end
endmodule : shift_rotate_table_ops_tb
`default_nettype wire
